//--- inc/irh_map.svh
// Behaviour
// (RULE1) Acknowledge read returns number, level; clears flag
// (RULE2) Any read of address zero clears winner
// (RULE3) Reset clears both stack pointers to zero
// (RULE4) First instruction after reset blocks all interrupts
// (RULE5) Non-maskable interrupt has no mask; pull-up
// (RULE6) Port eight bit five shows NMI pin
// (RULE7) NMI low forces all-clock-stop bit to zero
// (RULE8) NMI low in wait keeps CPU stopped
// (RULE9) NMI levels held two cycles plus 300ns
// (RULE10) Changing source or polarity may set flag
// (RULE11) Polarity or source select write sets flag; the code sets it only when the written value differs
// (RULE12) Rewrite control only while requests cannot occur
// (RULE13) Control write may lose simultaneous request
// (RULE14) Clear request flag with plain zero write
// (RULE15) Accept when enabled and level exceeds IPL
`ifndef IRH_MAP_SVH
`define IRH_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define IRH_ADDR_ACK     8'h00
`define IRH_CTRL_PAGE    5'h02
`define IRH_ADDR_SRCSEL  8'h20
`define IRH_ADDR_FLAGS   8'h21
`define IRH_ADDR_USP     8'h22
`define IRH_ADDR_ISP     8'h23
`define IRH_ADDR_PORT8   8'h24
`define IRH_ADDR_CLKC1   8'h25
`define IRH_ADDR_PEND    8'h26

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IRH_CTRL_LVL_LSB 0
`define IRH_CTRL_LVL_MSB 2
`define IRH_CTRL_FLAG    3
`define IRH_CTRL_POL     4
`define IRH_FLAGS_IPL_LSB 0
`define IRH_FLAGS_IPL_MSB 2
`define IRH_FLAGS_GIE    3
`define IRH_ACK_NUM_LSB  0
`define IRH_ACK_NUM_MSB  2
`define IRH_ACK_LVL_LSB  8
`define IRH_ACK_LVL_MSB  10
`define IRH_PORT8_NMI    5
`define IRH_CLKC1_STOP   0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IRH_SP_RST       16'h0000
`define IRH_SRCSEL_RST   8'h00
`define IRH_PIN_RST      7'h7F

`endif

//--- inc/irh_pkg.sv
package irh_pkg;

	// Per-source configuration fields
	typedef struct packed {
		logic       edge_polarity_bit;   // Edge polarity bit
		logic [2:0] lvl;   // Request priority level, zero disables
	} irh_ctrl_t;

	// Resolved highest-priority pending request
	typedef struct packed {
		logic       vld;   // Some enabled request pending
		logic [2:0] num;   // Interrupt number
		logic [2:0] lvl;   // Its priority level
	} irh_sel_t;

	// CPU flag word seen by the controller
	typedef struct packed {
		logic       gie;   // Global interrupt enable
		logic [2:0] ipl;   // Processor priority level
	} irh_flags_t;

endpackage

//--- src/irh_sync.sv
`timescale 1ns/1ps
module irh_sync #(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	input  wire logic         clk,    // System clock
	input  wire logic         rst_b,  // Async reset, active low
	input  wire logic [W-1:0] d,      // Asynchronous inputs
	output logic      [W-1:0] q       // Filtered synchronous levels
);

	logic [W-1:0] s1_q;  // First stage, read only by second
	logic [W-1:0] s2_q;  // Second stage
	logic [W-1:0] s3_q;  // Third stage
	logic [W-1:0] agree; // Second and third stage agree

	assign agree = ~(s2_q ^ s3_q);

	// Three-stage chain; a change counts once stages two and three agree
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
			q    <= RST_VAL;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			q    <= (agree & s3_q) | (~agree & q);
		end
	end

endmodule // irh_sync

//--- src/irh_top.sv
`timescale 1ns/1ps
`include "irh_map.svh"
module irh_top (
	input  wire logic        CLK,        // CPU clock, 25 MHz
	input  wire logic        RST_B,      // Async reset, active low
	input  wire logic [7:0]  ADDR,       // Register address
	input  wire logic [15:0] WDATA,      // Write data
	input  wire logic        WR,         // Write strobe
	input  wire logic        RD,         // Read strobe
	output logic      [15:0] RDATA,      // Read data, cycle after strobe
	input  wire logic [5:0]  INT_PIN,    // External interrupt pins
	input  wire logic        NMI_PIN_B,  // Non-maskable pin, active low
	input  wire logic [1:0]  PERIPH_REQ, // Peripheral request pulses
	input  wire logic        INSTR_DONE, // CPU finished an instruction
	input  wire logic        WAIT_ENTER, // CPU executes wait
	input  wire logic        NMI_ACK,    // CPU takes the NMI
	output logic             IRQ_REQ,    // Maskable request to CPU
	output logic      [2:0]  IRQ_NUM,    // Pending interrupt number
	output logic      [2:0]  IRQ_LVL,    // Pending priority level
	output logic             NMI_REQ,    // NMI request to CPU
	output logic             CLK_STOP,   // All-clock-stop bit
	output logic             CPU_HALT    // CPU stopped in wait
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	localparam int NSRC = 8;                 // Sources: six pins, two lines

	logic [6:0]          pin_raw;            // Pins into synchroniser
	logic [6:0]          pin_s;              // Synchronised pin levels
	logic [6:0]          pin_prev_q;         // Levels one cycle back
	logic [6:0]          rise;               // Rising edge per pin
	logic [6:0]          fall;               // Falling edge per pin
	logic                nmi_lvl;            // Synchronised NMI level
	logic                nmi_fall;           // NMI asserted edge
	logic [NSRC-1:0]     evt;                // Request events per source
	logic [NSRC-1:0]     spur;               // Spurious set on reconfig
	logic [NSRC-1:0]     wr_ctrl;            // Control write per source
	irh_pkg::irh_ctrl_t  ctrl_q [NSRC];      // Per-source configuration
	logic [NSRC-1:0]     flag_q;             // Request flags
	logic [7:0]          srcsel_q;           // External source select bits
	irh_pkg::irh_flags_t flags_q;            // Global enable and IPL
	logic [15:0]         usp_q;              // User stack pointer
	logic [15:0]         isp_q;              // Interrupt stack pointer
	logic                clk_stop_q;         // All-clock-stop bit
	logic                nmi_pend_q;         // NMI pending
	logic                first_instr_q;      // First instruction running
	logic                wait_q;             // CPU in wait
	logic                wait_nmi_q;         // NMI fell during wait
	irh_pkg::irh_sel_t   win;                // Highest-priority request
	logic                irq_ok;             // Accept condition
	logic                irq_req_q;          // Registered request
	logic [2:0]          irq_num_q;          // Registered number
	logic [2:0]          irq_lvl_q;          // Registered level
	logic                rd_ack;             // Read of address zero
	logic                wr_srcsel;          // Source select write
	logic [15:0]         ack_word;           // Acknowledge read value
	logic [15:0]         rd_mux;             // Read data selection
	logic [15:0]         rdata_q;            // Read data register
	logic                first_cyc_q;        // First cycle after reset

	// ------------------------------------------------------------
	// Pin synchronisation and edges
	// ------------------------------------------------------------
	assign pin_raw = {NMI_PIN_B, INT_PIN};

	irh_sync #(
		.W       (7),
		.RST_VAL (`IRH_PIN_RST)
	) u_sync (
		.clk   (CLK),
		.rst_b (RST_B),
		.d     (pin_raw),
		.q     (pin_s)
	);

	// Previous levels for edge detection
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			pin_prev_q <= `IRH_PIN_RST;
		end else begin
			pin_prev_q <= pin_s;
		end
	end

	assign rise     = pin_s & ~pin_prev_q;
	assign fall     = ~pin_s & pin_prev_q;
	assign nmi_lvl  = pin_s[6];
	assign nmi_fall = fall[6];

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	assign rd_ack    = RD && (ADDR == `IRH_ADDR_ACK);
	assign wr_srcsel = WR && (ADDR == `IRH_ADDR_SRCSEL);

	// One control register per source in one address page
	always_comb begin
		for (int i = 0; i < NSRC; i++) begin
			wr_ctrl[i] = WR && (ADDR[7:3] == `IRH_CTRL_PAGE) && (ADDR[2:0] == 3'(i));
		end
	end

	// ------------------------------------------------------------
	// Request events and reconfiguration sets
	// ------------------------------------------------------------
	// Pins use polarity or both edges; sources 6 and 7 pick a line or pin 4/5
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			if (srcsel_q[i]) begin
				evt[i] = rise[i] | fall[i];
			end else begin
				evt[i] = ctrl_q[i].edge_polarity_bit ? rise[i] : fall[i];
			end
		end
		for (int k = 0; k < 2; k++) begin
			if (srcsel_q[6+k]) begin
				evt[6+k] = ctrl_q[6+k].edge_polarity_bit ? rise[4+k] : fall[4+k];
			end else begin
				evt[6+k] = PERIPH_REQ[k];
			end
		end
	end

	// Changing polarity or source select raises the flag
	always_comb begin
		for (int i = 0; i < NSRC; i++) begin
			spur[i] = (wr_ctrl[i] && (WDATA[`IRH_CTRL_POL] != ctrl_q[i].edge_polarity_bit)) // RULE10
				|| (wr_srcsel && (WDATA[i] != srcsel_q[i])); // RULE11
		end
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	// Level and polarity per source
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			for (int i = 0; i < NSRC; i++) begin
				ctrl_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NSRC; i++) begin
				if (wr_ctrl[i]) begin
					ctrl_q[i].lvl <= WDATA[`IRH_CTRL_LVL_MSB:`IRH_CTRL_LVL_LSB];
					ctrl_q[i].edge_polarity_bit <= WDATA[`IRH_CTRL_POL];
				end
			end
		end
	end

	// Source select bits
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			srcsel_q <= `IRH_SRCSEL_RST;
		end else if (wr_srcsel) begin
			srcsel_q <= WDATA[7:0];
		end
	end

	// Global enable and processor priority level
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			flags_q <= '0;
		end else if (WR && (ADDR == `IRH_ADDR_FLAGS)) begin
			flags_q.gie <= WDATA[`IRH_FLAGS_GIE];
			flags_q.ipl <= WDATA[`IRH_FLAGS_IPL_MSB:`IRH_FLAGS_IPL_LSB];
		end
	end

	// Stack pointers start at zero; software loads them
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			usp_q <= `IRH_SP_RST; // RULE3
			isp_q <= `IRH_SP_RST; // RULE3
		end else begin
			if (WR && (ADDR == `IRH_ADDR_USP)) begin
				usp_q <= WDATA;
			end
			if (WR && (ADDR == `IRH_ADDR_ISP)) begin
				isp_q <= WDATA;
			end
		end
	end

	// ------------------------------------------------------------
	// Request flags
	// ------------------------------------------------------------
	// Control write replaces the flag, so an event in that cycle is lost;
	// otherwise an event beats the acknowledge clear
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			flag_q <= '0;
		end else begin
			for (int i = 0; i < NSRC; i++) begin
				if (wr_ctrl[i]) begin
					flag_q[i] <= WDATA[`IRH_CTRL_FLAG] | spur[i]; // RULE13 RULE14
				end else if (evt[i] || spur[i]) begin
					flag_q[i] <= 1'b1;
				end else if (rd_ack && win.vld && (win.num == 3'(i))) begin
					flag_q[i] <= 1'b0; // RULE1 RULE2
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Priority resolution and acceptance
	// ------------------------------------------------------------
	// Highest level wins; equal levels go to the lower number
	always_comb begin
		win = '0;
		for (int i = 0; i < NSRC; i++) begin
			if (flag_q[i] && (ctrl_q[i].lvl != 3'h0) && (!win.vld || (ctrl_q[i].lvl > win.lvl))) begin
				win.vld = 1'b1;
				win.num = 3'(i);
				win.lvl = ctrl_q[i].lvl;
			end
		end
	end

	assign irq_ok = win.vld && flags_q.gie && (win.lvl > flags_q.ipl) && !first_instr_q; // RULE15 RULE4

	// Registered request; dropped for the cycle after an acknowledge
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			irq_req_q <= 1'b0;
			irq_num_q <= 3'h0;
			irq_lvl_q <= 3'h0;
		end else begin
			irq_req_q <= irq_ok && !rd_ack;
			irq_num_q <= win.num;
			irq_lvl_q <= win.lvl;
		end
	end

	assign IRQ_REQ = irq_req_q;
	assign IRQ_NUM = irq_num_q;
	assign IRQ_LVL = irq_lvl_q;

	// ------------------------------------------------------------
	// Non-maskable interrupt and reset hold-off
	// ------------------------------------------------------------
	// First instruction after reset runs with everything held off
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			first_instr_q <= 1'b1;
		end else if (INSTR_DONE) begin
			first_instr_q <= 1'b0; // RULE4
		end
	end

	// NMI latch has no enable; new edge wins over acknowledge
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			nmi_pend_q <= 1'b0;
		end else if (nmi_fall) begin
			nmi_pend_q <= 1'b1; // RULE5
		end else if (NMI_ACK) begin
			nmi_pend_q <= 1'b0;
		end
	end

	assign NMI_REQ = nmi_pend_q && !first_instr_q; // RULE4

	// ------------------------------------------------------------
	// Stop and wait control
	// ------------------------------------------------------------
	// Stop bit held at zero while NMI is low; an accepted request or pending NMI clears it
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			clk_stop_q <= 1'b0;
		end else if (!nmi_lvl) begin
			clk_stop_q <= 1'b0; // RULE7
		end else if (irq_ok || nmi_pend_q) begin
			clk_stop_q <= 1'b0;
		end else if (WR && (ADDR == `IRH_ADDR_CLKC1)) begin
			clk_stop_q <= WDATA[`IRH_CLKC1_STOP];
		end
	end

	assign CLK_STOP = clk_stop_q;

	// First NMI fall in wait does not wake; a second NMI fall or an accepted request does
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			wait_q     <= 1'b0;
			wait_nmi_q <= 1'b0;
		end else if (!wait_q) begin
			wait_q     <= WAIT_ENTER;
			wait_nmi_q <= 1'b0;
		end else if (irq_ok || (nmi_fall && wait_nmi_q)) begin
			wait_q     <= 1'b0;
			wait_nmi_q <= 1'b0;
		end else if (nmi_fall) begin
			wait_nmi_q <= 1'b1; // RULE8
		end
	end

	assign CPU_HALT = wait_q;

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Acknowledge word: number low, level in upper byte
	always_comb begin
		ack_word = 16'h0000;
		ack_word[`IRH_ACK_NUM_MSB:`IRH_ACK_NUM_LSB] = win.num;
		ack_word[`IRH_ACK_LVL_MSB:`IRH_ACK_LVL_LSB] = win.lvl;
	end

	// Register selection; unmapped addresses read zero
	always_comb begin
		rd_mux = 16'h0000;
		if (ADDR[7:3] == `IRH_CTRL_PAGE) begin
			rd_mux[`IRH_CTRL_LVL_MSB:`IRH_CTRL_LVL_LSB] = ctrl_q[ADDR[2:0]].lvl;
			rd_mux[`IRH_CTRL_FLAG] = flag_q[ADDR[2:0]];
			rd_mux[`IRH_CTRL_POL]  = ctrl_q[ADDR[2:0]].edge_polarity_bit;
		end else begin
			case (ADDR)
				`IRH_ADDR_ACK:    rd_mux = ack_word; // RULE1
				`IRH_ADDR_SRCSEL: rd_mux[7:0] = srcsel_q;
				`IRH_ADDR_FLAGS: begin
					rd_mux[`IRH_FLAGS_GIE] = flags_q.gie;
					rd_mux[`IRH_FLAGS_IPL_MSB:`IRH_FLAGS_IPL_LSB] = flags_q.ipl;
				end
				`IRH_ADDR_USP:    rd_mux = usp_q;
				`IRH_ADDR_ISP:    rd_mux = isp_q;
				`IRH_ADDR_PORT8:  rd_mux[`IRH_PORT8_NMI] = nmi_lvl; // RULE6
				`IRH_ADDR_CLKC1:  rd_mux[`IRH_CLKC1_STOP] = clk_stop_q;
				`IRH_ADDR_PEND:   rd_mux[7:0] = flag_q;
				default:          rd_mux = 16'h0000;
			endcase
		end
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= RD ? rd_mux : 16'h0000;
		end
	end

	assign RDATA = rdata_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	// Marks the first clocked cycle after reset release
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			first_cyc_q <= 1'b1;
		end else begin
			first_cyc_q <= 1'b0;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	sequence s_ack_taken;
		rd_ack && win.vld && !evt[win.num] && !spur[win.num];
	endsequence

	sequence s_nmi_in_wait;
		wait_q && nmi_fall && !wait_nmi_q && !irq_ok;
	endsequence

	property p_ack_clear;
		s_ack_taken |=> !flag_q[$past(win.num)];
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("acknowledge did not clear flag"); // RULE1

	property p_ack_data;
		rd_ack |=> (RDATA == $past(ack_word)) ##1 ((RDATA == 16'h0000) || $past(RD));
	endproperty
	a_ack_data: assert property (p_ack_data) else $error("acknowledge data wrong"); // RULE1

	property p_sp_reset;
		first_cyc_q |-> (usp_q == 16'h0000) && (isp_q == 16'h0000);
	endproperty
	a_sp_reset: assert property (p_sp_reset) else $error("stack pointer not zero after reset"); // RULE3

	property p_first_hold;
		first_instr_q |-> !NMI_REQ && !irq_ok;
	endproperty
	a_first_hold: assert property (p_first_hold) else $error("interrupt during first instruction"); // RULE4

	property p_nmi_latch;
		nmi_fall ##1 !first_instr_q && !NMI_ACK |-> NMI_REQ;
	endproperty
	a_nmi_latch: assert property (p_nmi_latch) else $error("nmi edge not requested"); // RULE5

	property p_port8;
		RD && (ADDR == `IRH_ADDR_PORT8) |=> (RDATA[`IRH_PORT8_NMI] == $past(nmi_lvl));
	endproperty
	a_port8: assert property (p_port8) else $error("port eight nmi bit wrong"); // RULE6

	property p_stop_forced;
		!nmi_lvl |=> !CLK_STOP;
	endproperty
	a_stop_forced: assert property (p_stop_forced) else $error("stop bit set while nmi low"); // RULE7

	property p_wait_hold;
		s_nmi_in_wait |=> CPU_HALT;
	endproperty
	a_wait_hold: assert property (p_wait_hold) else $error("nmi woke cpu from wait"); // RULE8

	property p_srcsel_set;
		wr_srcsel && (WDATA[7:0] != srcsel_q) |=> &(flag_q | ~($past(WDATA[7:0]) ^ $past(srcsel_q)));
	endproperty
	a_srcsel_set: assert property (p_srcsel_set) else $error("source select change did not set flag"); // RULE11

	property p_write_lost;
		wr_ctrl[0] && !WDATA[`IRH_CTRL_FLAG] && !spur[0] |=> !flag_q[0];
	endproperty
	a_write_lost: assert property (p_write_lost) else $error("control write did not clear flag"); // RULE13

	property p_accept;
		IRQ_REQ |-> $past(flags_q.gie) && ($past(win.lvl) > $past(flags_q.ipl));
	endproperty
	a_accept: assert property (p_accept) else $error("request raised without enable or level"); // RULE15

endmodule // irh_top

//--- testbench/irh_src_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Far-side sources: external pins, NMI pin, peripheral requests
// ----------------------------------------------------------------
module irh_src_model (
	input  wire logic  clk,        // CPU clock
	output logic [5:0] int_pin,    // External interrupt pins
	output logic       nmi_pin_b,  // Non-maskable pin, active low
	output logic [1:0] periph_req  // Peripheral request pulses
);
	// Two CPU cycles plus 300 ns at 40 ns rounds up to ten cycles
	localparam int MIN_CYC = 10;

	// Idle levels: pins pulled high, no peripheral events
	initial begin
		int_pin    = 6'h3F;
		nmi_pin_b  = 1'h1;
		periph_req = 2'h0;
	end

	// One-cycle peripheral event on the chosen line
	task automatic periph_pulse(input int idx);
		@(posedge clk);
		periph_req[idx] <= 1'h1;
		@(posedge clk);
		periph_req <= 2'h0;
	endtask

	// Move the NMI pin, then hold the level for the minimum width
	task automatic nmi_set(input logic lvl);
		@(posedge clk);
		nmi_pin_b <= lvl;
		repeat (MIN_CYC) @(posedge clk);
	endtask

	// Move one external pin and hold it long enough to be filtered
	task automatic pin_set(input int idx, input logic lvl);
		@(posedge clk);
		int_pin[idx] <= lvl;
		repeat (MIN_CYC) @(posedge clk);
	endtask
endmodule // irh_src_model

//--- testbench/irh_top_tb.sv
`timescale 1ns/1ps
module irh_top_tb;
	// ----------------------------------------------------------------
	// Signals and table
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        wr;    // Write before the read
		logic [7:0]  addr;  // Register address
		logic [15:0] wdata; // Write data
		logic [15:0] exp;   // Expected read data
	} irh_row_t;

	logic        CLK = 1'h0;     // CPU clock
	logic        RST_B;          // Reset, active low
	logic [7:0]  ADDR;           // Bus address
	logic [15:0] WDATA;          // Bus write data
	logic        WR;             // Write strobe
	logic        RD;             // Read strobe
	logic        INSTR_DONE, WAIT_ENTER, NMI_ACK; // CPU pulses
	logic [15:0] RDATA;          // Read data
	logic [5:0]  INT_PIN;        // From source model
	logic        NMI_PIN_B;      // From source model
	logic [1:0]  PERIPH_REQ;     // From source model
	logic        IRQ_REQ, NMI_REQ, CLK_STOP, CPU_HALT; // Status outputs
	logic [2:0]  IRQ_NUM, IRQ_LVL; // Winner number and level
	int          num_errors = 0; // Mismatch count
	int          check_count = 0; // Comparison count

	// Reset values, then write-back, unmapped places read zero
	localparam irh_row_t ROWS [9] = '{
		'{1'h0, 8'h22, 16'h0000, 16'h0000}, '{1'h0, 8'h23, 16'h0000, 16'h0000},
		'{1'h0, 8'h21, 16'h0000, 16'h0000}, '{1'h0, 8'h20, 16'h0000, 16'h0000},
		'{1'h0, 8'h26, 16'h0000, 16'h0000}, '{1'h0, 8'h24, 16'h0000, 16'h0020},
		'{1'h1, 8'h22, 16'h1234, 16'h1234}, '{1'h1, 8'h23, 16'hABCD, 16'hABCD},
		'{1'h1, 8'h7F, 16'hFFFF, 16'h0000}};

	always #20 CLK = ~CLK;

	irh_src_model i_src (.clk(CLK), .int_pin(INT_PIN), .nmi_pin_b(NMI_PIN_B), .periph_req(PERIPH_REQ));

	irh_top i_dut (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .INT_PIN(INT_PIN), .NMI_PIN_B(NMI_PIN_B), .PERIPH_REQ(PERIPH_REQ),
		.INSTR_DONE(INSTR_DONE), .WAIT_ENTER(WAIT_ENTER), .NMI_ACK(NMI_ACK), .IRQ_REQ(IRQ_REQ),
		.IRQ_NUM(IRQ_NUM), .IRQ_LVL(IRQ_LVL), .NMI_REQ(NMI_REQ), .CLK_STOP(CLK_STOP), .CPU_HALT(CPU_HALT));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	// Compare and count
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One-cycle write
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'h1;
		@(posedge CLK);
		WR <= 1'h0;
	endtask

	// One-cycle read, data checked in the following cycle
	task automatic rd(input string nm, input logic [7:0] a, input logic [15:0] e);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'h1;
		@(posedge CLK);
		RD <= 1'h0;
		#1 chk(nm, e, RDATA);
	endtask

	// CPU pulse: 0 instruction done, 1 wait entry, other NMI taken
	task automatic pulse(input int sel);
		@(posedge CLK);
		case (sel)
			0: INSTR_DONE <= 1'h1;
			1: WAIT_ENTER <= 1'h1;
			default: NMI_ACK <= 1'h1;
		endcase
		@(posedge CLK);
		{INSTR_DONE, WAIT_ENTER, NMI_ACK} <= 3'h0;
		#1;
	endtask

	// Hold reset low for five cycles
	task automatic do_reset();
		@(posedge CLK);
		RST_B <= 1'h0;
		repeat (5) @(posedge CLK);
		RST_B <= 1'h1;
	endtask

	// Verdict and end of run
	task automatic wrap_up();
		$display("Comparisons %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	initial begin
		#(40 * 5000);
		num_errors++;
		wrap_up();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		RST_B = 1'h0;
		ADDR = 8'h00;
		WDATA = 16'h0000;
		WR = 1'h0;
		RD = 1'h0;
		{INSTR_DONE, WAIT_ENTER, NMI_ACK} = 3'h0;
		repeat (5) @(posedge CLK);
		RST_B <= 1'h1;
		foreach (ROWS[i]) begin
			if (ROWS[i].wr) wr(ROWS[i].addr, ROWS[i].wdata);
			rd("table", ROWS[i].addr, ROWS[i].exp);
		end
		$display("table done");
		// Nothing passes before the first instruction ends
		wr(8'h16, 16'h0003);
		wr(8'h21, 16'h0008);
		i_src.periph_pulse(0);
		i_src.nmi_set(1'h0);
		#1 chk("irq first", 16'h0000, 16'(IRQ_REQ));
		chk("nmi first", 16'h0000, 16'(NMI_REQ));
		i_src.nmi_set(1'h1);
		pulse(0);
		repeat (2) @(posedge CLK);
		#1 chk("irq after", 16'h0001, 16'(IRQ_REQ));
		chk("num", 16'h0006, 16'(IRQ_NUM));
		chk("lvl", 16'h0003, 16'(IRQ_LVL));
		pulse(2);
		rd("ack", 8'h00, 16'h0306);
		chk("irq ack", 16'h0000, 16'(IRQ_REQ));
		rd("flag ack", 8'h16, 16'h0003);
		$display("acknowledge done");
		// NMI ignores the global enable; pin level and stop bit
		wr(8'h21, 16'h0000);
		i_src.nmi_set(1'h0);
		#1 chk("nmi req", 16'h0001, 16'(NMI_REQ));
		rd("pin low", 8'h24, 16'h0000);
		wr(8'h25, 16'h0001);
		rd("stop low", 8'h25, 16'h0000);
		chk("clk stop", 16'h0000, 16'(CLK_STOP));
		pulse(2);
		chk("nmi clr", 16'h0000, 16'(NMI_REQ));
		i_src.nmi_set(1'h1);
		wr(8'h25, 16'h0001);
		#1 chk("clk stop hi", 16'h0001, 16'(CLK_STOP));
		wr(8'h25, 16'h0000);
		$display("nmi done");
		// Level not above the processor level, then disabled
		wr(8'h21, 16'h000B);
		i_src.periph_pulse(0);
		repeat (4) @(posedge CLK);
		#1 chk("irq ipl", 16'h0000, 16'(IRQ_REQ));
		rd("flag kept", 8'h16, 16'h000B);
		wr(8'h21, 16'h0002);
		rd("soft ack", 8'h00, 16'h0306);
		rd("soft clr", 8'h16, 16'h0003);
		// Event lost beside a write to its own control
		fork
			wr(8'h16, 16'h0003);
			i_src.periph_pulse(0);
		join
		rd("lost", 8'h16, 16'h0003);
		$display("masking done");
		// Polarity and source changes set the flag
		wr(8'h10, 16'h0010);
		rd("pol set", 8'h10, 16'h0018);
		wr(8'h10, 16'h0010);
		rd("zero clr", 8'h10, 16'h0010);
		wr(8'h20, 16'h0080);
		rd("src set", 8'h26, 16'h0080);
		wr(8'h17, 16'h0000);
		rd("src clr", 8'h26, 16'h0000);
		$display("source change done");
		// Wait: first NMI fall keeps the CPU halted, pin request wakes it
		wr(8'h11, 16'h0002);
		wr(8'h21, 16'h0008);
		pulse(1);
		chk("halt", 16'h0001, 16'(CPU_HALT));
		i_src.nmi_set(1'h0);
		#1 chk("halt nmi", 16'h0001, 16'(CPU_HALT));
		pulse(2);
		i_src.nmi_set(1'h1);
		i_src.pin_set(1, 1'h0);
		#1 chk("wake num", 16'h0001, 16'(IRQ_NUM));
		chk("wake", 16'h0000, 16'(CPU_HALT));
		rd("pin ack", 8'h00, 16'h0201);
		i_src.pin_set(1, 1'h1);
		// Source seven taken from pin five on its rising edge
		wr(8'h17, 16'h0011);
		rd("pol7 set", 8'h17, 16'h0019);
		wr(8'h17, 16'h0011);
		i_src.pin_set(5, 1'h0);
		i_src.pin_set(5, 1'h1);
		rd("pin five", 8'h26, 16'h00A0);
		$display("wait done");
		// Reset in mid-run clears the stack pointers again
		wr(8'h22, 16'h5555);
		wr(8'h23, 16'hAAAA);
		do_reset();
		rd("usp", 8'h22, 16'h0000);
		rd("isp", 8'h23, 16'h0000);
		$display("second reset done");
		wrap_up();
	end
endmodule // irh_top_tb
